// [hw/tmrwc_pkg.sv]
// package of constants for the event/window/capture/pulse-generation timer
// Functional notes
// - event mode counts each selected edge of the input pin
// - event mode: match with A raises irq, clears counter, counting resumes
// - event match is checked at the edge opposite the counting edge
// - auto-capture copies the count into register B every source tick while started
// - window mode counts source ticks while pin is at the chosen level
// - window mode: match with A raises irq and clears counter
// - measurement starts on trigger edge; style bit picks single or double edge
// - single edge: capture, irq, clear to one-hold, restart on next trigger
// - double edge: capture at opposite and trigger edges, clear at trigger
// - pulse mode starts on pin edge or command; repeat bit picks one-shot
// - continuous: toggle at B, toggle and clear at A, irq on each
// - start field written 00 stops counter, output keeps its level
// - one-shot: toggle and irq at B and at A; at A start field cleared to 00, stop
// - output pin is inverse of flip-flop; preset 0 high, 1 low; reset 0
package tmrwc_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_REG_A = 4'h4;
    localparam logic [3:0] ADDR_REG_B = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hC;
    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int MODE_LSB = 0;     // operating_mode_field, 2 bits
    localparam int START_LSB = 2;    // start_edge_select, 2 bits
    localparam int CLKSEL_LSB = 4;   // source_clock_select, 3 bits
    localparam int ACAP_BIT = 7;     // auto_capture_enable
    localparam int STYLE_BIT = 8;    // capture_style_select / oneshot_select
    localparam int PRESET_BIT = 9;   // output_ff_preset
    localparam int CTRL_W = 10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [15:0] REG_RST = 16'h0000;
    // start field codes
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_CMD = 2'h1;
    localparam logic [1:0] START_RISE = 2'h2;
    localparam logic [1:0] START_FALL = 2'h3;
    // ************************************************************
    // modes and timing
    // ************************************************************
    typedef enum logic [1:0] {
        TMRWC_TIMER, TMRWC_EVENT_WIN, TMRWC_MEASURE, TMRWC_PULSE
    } tmrwc_mode_t;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MIN_LEVEL_NS = 32;   // eight clocks at 4 ns
    localparam int MIN_LEVEL_CYC = (MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : tmrwc_pkg

// [hw/tmrwc_top.sv]
// timer/counter with event, window, pulse measurement and pulse generation
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tmrwc_top
    import tmrwc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic TIMER_INPUT_PIN,
    input wire logic WINDOW_SELECT,
    output logic PULSE_GEN_OUTPUT,
    output logic TIMER_IRQ,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    import tmrwc_pkg::*;

    initial begin
        if (CNT_W != 16) begin
            $error("counter width must be 16");
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [CTRL_W-1:0] ctrl_r;
    logic [15:0] reg_a_r;
    logic [15:0] reg_b_r;
    logic [15:0] count_r;
    logic [7:0] div_r;
    logic pin_d_r;
    logic ff_r;
    logic running_r;
    logic phase_r;       // double-edge: opposite edge already seen

    // ************************************************************
    // control decode
    // ************************************************************
    wire [1:0] mode = ctrl_r[MODE_LSB +: 2];
    wire [1:0] start_sel = ctrl_r[START_LSB +: 2];
    wire [2:0] clk_sel = ctrl_r[CLKSEL_LSB +: 3];
    wire acap = ctrl_r[ACAP_BIT];
    wire style = ctrl_r[STYLE_BIT];
    wire started = start_sel != START_STOP;
    wire is_event = mode == 2'(TMRWC_EVENT_WIN) && !WINDOW_SELECT;
    wire is_window = mode == 2'(TMRWC_EVENT_WIN) && WINDOW_SELECT;
    wire is_measure = mode == 2'(TMRWC_MEASURE);
    wire is_pulse = mode == 2'(TMRWC_PULSE);

    // source tick: one-cycle enable from the free divider, 2^sel clocks
    wire [7:0] div_inc = div_r + 8'h01;
    wire [7:0] tick_mask = 8'((9'h001 << clk_sel) - 9'h001);
    wire tick = (div_r & tick_mask) == 8'h00;

    // pin edges; rising selection uses falling as opposite and vice versa
    wire rise = TIMER_INPUT_PIN && !pin_d_r;
    wire fall = !TIMER_INPUT_PIN && pin_d_r;
    wire trig_edge = start_sel[0] ? fall : rise;
    wire opp_edge = start_sel[0] ? rise : fall;
    wire edge_mode = start_sel[1];

    wire [15:0] cnt_inc = count_r + 16'h0001;
    wire match_a = count_r == reg_a_r;
    wire match_b = count_r == reg_b_r;
    // window gate: positive logic counts at high level, negative at low
    wire gate = start_sel[0] ? !TIMER_INPUT_PIN : TIMER_INPUT_PIN;

    // ************************************************************
    // counting engine (combinational)
    // ************************************************************
    logic [15:0] count_nxt;
    logic [15:0] cap_nxt;
    logic cap_load;
    logic irq_nxt;
    logic ff_toggle;
    logic run_nxt;
    logic phase_nxt;
    logic stop_cmd;
    always_comb begin
        count_nxt = count_r;
        cap_nxt = count_r;
        cap_load = 1'b0;
        irq_nxt = 1'b0;
        ff_toggle = 1'b0;
        run_nxt = running_r;
        phase_nxt = phase_r;
        stop_cmd = 1'b0;
        if (!started) begin
            run_nxt = 1'b0;
            phase_nxt = 1'b0;
            count_nxt = 16'h0000;
        end else if (is_event) begin
            if (trig_edge) begin
                count_nxt = cnt_inc;
            end else if (opp_edge && match_a) begin
                count_nxt = 16'h0000;
                irq_nxt = 1'b1;
            end
        end else if (is_window) begin
            if (tick && gate) begin
                if (match_a) begin
                    count_nxt = 16'h0000;
                    irq_nxt = 1'b1;
                end else begin
                    count_nxt = cnt_inc;
                end
            end
        end else if (is_measure && edge_mode) begin
            if (!running_r) begin
                if (trig_edge) begin
                    run_nxt = 1'b1;
                    phase_nxt = 1'b0;
                end
            end else if (opp_edge && !phase_r) begin
                cap_load = 1'b1;
                irq_nxt = 1'b1;
                if (style) begin
                    count_nxt = 16'h0001;
                    run_nxt = 1'b0;                           // parked at one
                end else begin
                    phase_nxt = 1'b1;
                    if (tick) count_nxt = cnt_inc;
                end
            end else if (trig_edge && phase_r) begin
                cap_load = 1'b1;
                irq_nxt = 1'b1;
                phase_nxt = 1'b0;
                count_nxt = 16'h0000;
            end else if (tick) begin
                count_nxt = cnt_inc;
            end
        end else if (is_pulse) begin
            if (!running_r) begin
                run_nxt = (start_sel == START_CMD) || trig_edge;
            end else if (tick) begin
                if (match_a) begin
                    ff_toggle = 1'b1;
                    irq_nxt = 1'b1;
                    count_nxt = 16'h0000;
                    stop_cmd = style;
                end else begin
                    if (match_b) begin
                        ff_toggle = 1'b1;
                        irq_nxt = 1'b1;
                    end
                    count_nxt = cnt_inc;
                end
            end
        end
        // auto-capture follows the source tick while the timer is started
        if (acap && started && tick && !cap_load) begin
            cap_load = 1'b1;
            cap_nxt = count_r;
        end
    end

    // ************************************************************
    // bus slave: write and read channels
    // ************************************************************
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
    wire wr_ctrl = wr_go && aw_addr_r == ADDR_CTRL;
    wire wr_a = wr_go && aw_addr_r == ADDR_REG_A;
    wire wr_b = wr_go && aw_addr_r == ADDR_REG_B;
    wire wr_ok = wr_ctrl || wr_a || wr_b;
    // byte-lane merge for each writable register
    wire [15:0] lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [15:0] ctrl_wide = {6'h00, ctrl_r};
    wire [15:0] ctrl_merge = (ctrl_wide & ~lane_mask) | (w_data_r[15:0] & lane_mask);
    wire [15:0] a_merge = (reg_a_r & ~lane_mask) | (w_data_r[15:0] & lane_mask);
    wire [15:0] b_merge = (reg_b_r & ~lane_mask) | (w_data_r[15:0] & lane_mask);
    wire [3:0] rd_addr = S_AXI_ARADDR[3:0];
    wire rd_hit = S_AXI_ARADDR[31:4] == 28'h0000000 && rd_addr[1:0] == 2'h0;
    wire [15:0] rd_val = rd_addr == ADDR_CTRL ? ctrl_wide :
                         rd_addr == ADDR_REG_A ? reg_a_r :
                         rd_addr == ADDR_REG_B ? reg_b_r : count_r;
    wire aw_hit = S_AXI_AWADDR[31:4] == 28'h0000000;

    // write handshake; address and data taken in either order
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            S_AXI_AWREADY <= !aw_held_r && !aw_take && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held_r && !w_take && !S_AXI_BVALID;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= aw_hit ? S_AXI_AWADDR[3:0] : 4'h3;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? 2'h0 : 2'h2;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // read handshake; unmapped addresses answer slave error
    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h0;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_hit ? {16'h0000, rd_val} : 32'h00000000;
                S_AXI_RRESP <= rd_hit ? 2'h0 : 2'h2;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ************************************************************
    // timer state
    // ************************************************************
    // control: hardware clear of the start field wins over a software write
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_r <= CTRL_RST;
            reg_a_r <= REG_RST;
            reg_b_r <= REG_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= ctrl_merge[CTRL_W-1:0];
            if (stop_cmd) ctrl_r[START_LSB +: 2] <= START_STOP;
            if (wr_a) reg_a_r <= a_merge;
            if (wr_b) reg_b_r <= b_merge;
            else if (cap_load) reg_b_r <= cap_nxt;
        end
    end

    // counter, divider and sequencing flags
    always_ff @(posedge CLK) begin
        if (RST) begin
            count_r <= 16'h0000;
            div_r <= 8'h00;
            pin_d_r <= TIMER_INPUT_PIN;   // track the pin so no false edge follows reset
            running_r <= 1'b0;
            phase_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            div_r <= div_inc;
            pin_d_r <= TIMER_INPUT_PIN;
            running_r <= run_nxt && !stop_cmd;
            phase_r <= phase_nxt;
        end
    end

    // output flip-flop: a control write while running_r is clear loads preset
    always_ff @(posedge CLK) begin
        if (RST) begin
            ff_r <= 1'b0;
            PULSE_GEN_OUTPUT <= 1'b1;
            TIMER_IRQ <= 1'b0;
        end else begin
            if (wr_ctrl && !running_r) begin
                ff_r <= ctrl_merge[PRESET_BIT];
                PULSE_GEN_OUTPUT <= !ctrl_merge[PRESET_BIT];
            end else if (ff_toggle) begin
                ff_r <= !ff_r;
                PULSE_GEN_OUTPUT <= ff_r;
            end
            TIMER_IRQ <= irq_nxt;
        end
    end
endmodule : tmrwc_top

// [verif/tmrwc_assertions.sv]
// port checker for the timer block and its bind
`timescale 1ns/1ps
module tmrwc_checker
    import tmrwc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PULSE_GEN_OUTPUT,
    input wire logic TIMER_IRQ,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ****************
    // port properties
    // ****************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_reset_state: assert property ($fell(RST) |-> PULSE_GEN_OUTPUT && !TIMER_IRQ
        && !S_AXI_BVALID && !S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("state after reset wrong");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID)
        else $error("write response missing");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    a_bvalid_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response repeated");
    a_rvalid_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read response repeated");
    a_busy_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");
    a_toggle_cause: assert property ($changed(PULSE_GEN_OUTPUT) |->
        TIMER_IRQ || $rose(S_AXI_BVALID))
        else $error("output changed without cause");
    a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // main scenarios seen
    c_irq: cover property (TIMER_IRQ);
    c_out_fall: cover property ($fell(PULSE_GEN_OUTPUT));
    c_read: cover property (S_AXI_RVALID);
endmodule : tmrwc_checker

bind tmrwc_top tmrwc_checker #(.CNT_W(CNT_W)) tmrwc_checker_i (.CLK(CLK), .RST(RST),
    .PULSE_GEN_OUTPUT(PULSE_GEN_OUTPUT), .TIMER_IRQ(TIMER_IRQ),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// [verif/tmrwc_source.sv]
// pulse source model driving the timer input pin
`timescale 1ns/1ps
module tmrwc_source
    import tmrwc_pkg::*;
(
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b0;
    // ************
    // level driver
    // ************
    // short requests are stretched so no edge is ever missed
    task automatic hold(input logic lvl, input int cyc);
        int n = (cyc < MIN_LEVEL_CYC) ? MIN_LEVEL_CYC : cyc;
        pin <= lvl; // levels far slower than a tick
        repeat (n) @(posedge clk);
    endtask : hold
endmodule : tmrwc_source

// [verif/tb.sv]
// self-checking testbench for the timer block
`timescale 1ns/1ps
module tb;
    import tmrwc_pkg::*;
    logic clk = 0, rst = 1, win = 0, awv = 0, wv = 0, arv = 0, bready = 1, rready = 1;
    logic pin, pgo, irq, awr, wr, bv, arr, rv;
    logic [1:0] br, rr, resp;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd, v;
    logic [31:0] b[4];
    int failures = 0, comparisons = 0, cycles = 0, irq_cnt = 0, base;
    localparam logic [31:0] CA = 32'(ADDR_CTRL), RA = 32'(ADDR_REG_A), RB = 32'(ADDR_REG_B);
    tmrwc_top tmrwc_top_i (.CLK(clk), .RST(rst), .TIMER_INPUT_PIN(pin), .WINDOW_SELECT(win),
        .PULSE_GEN_OUTPUT(pgo), .TIMER_IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
    tmrwc_source tmrwc_source_i (.clk(clk), .pin(pin));
    initial forever #2 clk = ~clk;
    // interrupt tally and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    // ************
    // bench tasks
    // ************
    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // ready lines stay high, so the answer is taken at the edge it is seen
    task automatic wr_reg(input logic [31:0] a, d);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (bv !== 1'b1);
        resp = br;
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] a);
        araddr <= a;
        arv <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (rv !== 1'b1);
        v = rd;
        resp = rr;
    endtask : rd_reg
    function automatic logic [31:0] cw(input logic [1:0] m, s, input logic ac, st, pr);
        cw = (32'(m) << MODE_LSB) | (32'(s) << START_LSB) | (32'(ac) << ACAP_BIT)
            | (32'(st) << STYLE_BIT) | (32'(pr) << PRESET_BIT);
    endfunction : cw
    task automatic wait_irq(input int n);
        int lim = 0;
        while (irq_cnt - base < n && lim < 400) begin
            @(posedge clk);
            lim++;
        end
        check("irq count", 32'(irq_cnt - base), 32'(n));
    endtask : wait_irq
    task automatic do_reset();
        rst <= 1;
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
    endtask : do_reset
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ************
    // test sequence
    // ************
    initial begin
        do_reset();
        for (int i = 0; i < 4; i++) begin
            rd_reg(32'(4 * i));
            check("reset value", v, 32'h0);
        end
        check("output after reset", 32'(pgo), 32'h1);
        wr_reg(RA, 32'hABCD1234);
        rd_reg(RA);
        check("reg a width", v, 32'h00001234);
        wr_reg(32'h10, 32'h1);
        check("unmapped write", 32'(resp), 32'h2);
        rd_reg(32'h10);
        check("unmapped read", {v[29:0], resp}, 32'h2);
        $display("test registers done");
        // event counting, both polarities, match value three
        wr_reg(RA, 32'h3);
        for (int p = 0; p < 2; p++) begin
            tmrwc_source_i.hold(p[0], 10);
            wr_reg(CA, cw(2'h1, p ? START_FALL : START_RISE, 1, 0, 0));
            base = irq_cnt;
            for (int k = 1; k <= 6; k++) begin
                tmrwc_source_i.hold(!p[0], 10);
                check("irq at count edge", 32'(irq_cnt - base), 32'((k - 1) / 3));
                tmrwc_source_i.hold(p[0], 10);
                check("irq after match", 32'(irq_cnt - base), 32'(k / 3));
                rd_reg(32'(ADDR_COUNT));
                check("event count", v, 32'(k % 3));
                rd_reg(RB);
                check("auto capture", v, 32'(k % 3));
            end
            wr_reg(CA, 32'h0);
        end
        $display("test event done");
        // window gating, both polarities
        wr_reg(RA, 32'h5);
        win <= 1;
        for (int p = 0; p < 2; p++) begin
            tmrwc_source_i.hold(p[0], 10);
            wr_reg(CA, cw(2'h1, p ? START_FALL : START_RISE, 0, 0, 0));
            base = irq_cnt;
            tmrwc_source_i.hold(p[0], 40);
            check("window closed", 32'(irq_cnt - base), 32'h0);
            tmrwc_source_i.hold(!p[0], 40);
            check("window open", 32'(irq_cnt - base > 4), 32'h1);
            wr_reg(CA, 32'h0);
        end
        // divided source clock: 40 open cycles give ten ticks at select 2
        wr_reg(RA, 32'hFF);
        wr_reg(CA, cw(2'h1, START_RISE, 0, 0, 0) | (32'h2 << CLKSEL_LSB));
        tmrwc_source_i.hold(1, 40);
        tmrwc_source_i.hold(0, 10);
        rd_reg(32'(ADDR_COUNT));
        check("divided ticks", v, 32'd10);
        wr_reg(CA, 32'h0);
        win <= 0;
        $display("test window done");
        // single then double edge capture; captures read before next trigger
        tmrwc_source_i.hold(0, 10);
        for (int s = 1; s >= 0; s--) begin
            wr_reg(CA, cw(2'h2, START_RISE, 0, s[0], 0));
            base = irq_cnt;
            tmrwc_source_i.hold(1, 30);
            for (int k = 0; k < 4 - s; k++) begin
                fork
                    tmrwc_source_i.hold(s ? 1'b0 : k[0], (s || k[0]) ? 30 : 50);
                    begin
                        repeat (6) @(posedge clk);
                        rd_reg(RB);
                    end
                join
                b[k] = v;
                if (s == 1 && k < 2) tmrwc_source_i.hold(1, 30 + 10 * k);
            end
            if (s == 1) begin
                check("single edge width", b[2] - b[1], 32'd10);
                check("single edge irqs", 32'(irq_cnt - base), 32'd3);
            end else begin
                check("double edge period", b[3] - b[2], 32'd50);
                check("double edge clear", 32'(b[2] < 32'd40), 32'h1);
                check("double edge irqs", 32'(irq_cnt - base), 32'd4);
            end
            wr_reg(CA, 32'h0);
        end
        $display("test measure done");
        // second reset mid-run, then continuous and one-shot generation
        do_reset();
        wr_reg(RA, 32'd20);
        wr_reg(CA, cw(2'h3, START_STOP, 0, 0, 0));
        wr_reg(RB, 32'd8);
        wr_reg(CA, cw(2'h3, START_CMD, 0, 0, 0));
        base = irq_cnt;
        for (int k = 1; k <= 6; k++) begin
            wait_irq(k);
            b[k % 2] = 32'(cycles);
            @(posedge clk);
            check("pulse level", 32'(pgo), 32'(k % 2 == 0));
            if (k == 4) wr_reg(RA, 32'd40);
        end
        check("updated period", b[0] - b[1], 32'd32);
        wr_reg(CA, cw(2'h3, START_STOP, 0, 0, 0));
        b[0] = 32'(pgo);
        base = irq_cnt;
        repeat (60) @(posedge clk);
        check("stopped level", 32'(pgo), b[0]);
        check("stopped irqs", 32'(irq_cnt - base), 32'h0);
        wr_reg(CA, 32'h0);
        wr_reg(CA, cw(2'h3, START_STOP, 0, 1, 1));
        check("preset low", 32'(pgo), 32'h0);
        wr_reg(CA, cw(2'h3, START_RISE, 0, 1, 1));
        base = irq_cnt;
        tmrwc_source_i.hold(0, 60);
        check("waits for edge", 32'(irq_cnt - base), 32'h0);
        tmrwc_source_i.hold(1, 10);
        wait_irq(2);
        repeat (60) @(posedge clk);
        check("one-shot irqs", 32'(irq_cnt - base), 32'd2);
        check("one-shot level", 32'(pgo), 32'h0);
        rd_reg(CA);
        check("start field cleared", v, cw(2'h3, START_STOP, 0, 1, 1));
        $display("test pulse done");
        complete_run();
    end
endmodule : tb
